// file: sim/ccps_seq_chk.sv
// Purpose: port checker for the charge cycle and power path sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every ccps_sequencer instance
`timescale 1ns/1ns
////////////////////////////////////////
module ccps_seq_chk #(
  parameter DEAD_CYC = 1250,
  parameter IREF_W   = 8
) (
  input wire              mclk,
  input wire              arst_n,
  input wire              undervoltage_lockout,
  input wire              supply_above_node,
  input wire              input_overvoltage,
  input wire              die_overheat_shutdown,
  input wire              thermistor_fault,
  input wire [1:0]        timer_capacitor_pin,
  input wire [IREF_W-1:0] fast_current_setting,
  input wire [IREF_W-1:0] low_current_setting,
  input wire [IREF_W-1:0] current_ref,
  input wire              charging,
  input wire              precharging,
  input wire              charge_done,
  input wire              fault,
  input wire              sleep_mode,
  input wire              adapter_gate_drive,
  input wire              battery_gate_drive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // cycles with both switches off
  reg [15:0] off_cnt_r;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      off_cnt_r <= 16'h0000;
    else if (adapter_gate_drive || battery_gate_drive)
      off_cnt_r <= 16'h0000;
    else
      off_cnt_r <= off_cnt_r + 16'h0001;
  end
  ////////////////////////////////////////
  a_gates_never_both: assert property (!(adapter_gate_drive && battery_gate_drive))
    else $error("both switches on");
  a_dead_to_ac: assert property ($rose(adapter_gate_drive) |-> off_cnt_r >= DEAD_CYC)
    else $error("short dead time before adapter");
  a_dead_to_bat: assert property ($rose(battery_gate_drive) && !undervoltage_lockout &&
    !$past(undervoltage_lockout) |-> off_cnt_r >= DEAD_CYC) else $error("short dead time before battery");
  a_undervoltage_lockout_forced: assert property (undervoltage_lockout [*3] |-> !adapter_gate_drive && !charging)
    else $error("lockout not forcing off");
  a_stop_on_fault: assert property ((input_overvoltage || die_overheat_shutdown ||
    thermistor_fault) [*3] |-> !charging) else $error("charging during fault");
  a_sleep_quiet: assert property (!supply_above_node [*3] |-> sleep_mode && !charging)
    else $error("no sleep on low supply");
  a_pre_ref_low: assert property (precharging && $past(precharging) |->
    current_ref == low_current_setting) else $error("precharge reference wrong");
  a_term_blocked: assert property ((timer_capacitor_pin == 2'b00) [*2] |-> !$rose(charge_done))
    else $error("termination with timer pin low");
  a_ramp_first: assert property ($rose(charging) && !precharging |->
    current_ref == (fast_current_setting >> 3)) else $error("ramp first step wrong");
  a_ref_capped: assert property (charging && !precharging && $past(charging && !precharging) |->
    current_ref <= fast_current_setting) else $error("reference above setting");
  c_done: cover property ($rose(charge_done));
  c_fault: cover property ($rose(fault));
  c_adapter: cover property ($rose(adapter_gate_drive));
  c_pre: cover property ($rose(precharging));
endmodule
bind ccps_sequencer ccps_seq_chk #(.DEAD_CYC(DEAD_CYC), .IREF_W(IREF_W)) chk_u (
  .mclk                  (mclk),
  .arst_n                (arst_n),
  .undervoltage_lockout  (undervoltage_lockout),
  .supply_above_node     (supply_above_node),
  .input_overvoltage     (input_overvoltage),
  .die_overheat_shutdown (die_overheat_shutdown),
  .thermistor_fault      (thermistor_fault),
  .timer_capacitor_pin   (timer_capacitor_pin),
  .fast_current_setting  (fast_current_setting),
  .low_current_setting   (low_current_setting),
  .current_ref           (current_ref),
  .charging              (charging),
  .precharging           (precharging),
  .charge_done           (charge_done),
  .fault                 (fault),
  .sleep_mode            (sleep_mode),
  .adapter_gate_drive    (adapter_gate_drive),
  .battery_gate_drive    (battery_gate_drive)
);

// file: sim/tb.sv
// Purpose: self-checking bench for ccps_sequencer
// Assumes: shortened counts, 125 MHz mclk
// Notes:   faults driven through one vector
`timescale 1ns/1ns
////////////////////////////////////////
module tb;
  localparam TK = 4;
  localparam PW = 3;
  localparam DC = 5;
  localparam ST = 2;
  localparam TN = 2;
  localparam PT = 50;
  reg        mclk = 1'b0;
  reg        arst_n = 1'b0;
  reg        battery_low = 1'b0;
  reg        below_recharge = 1'b0;
  reg        current_below_term = 1'b0;
  reg        voltage_reg_phase = 1'b0;
  reg        supply_near_node = 1'b0;
  reg  [8:0] bad = 9'h000;
  reg  [1:0] timer_capacitor_pin = 2'b10;
  reg  [7:0] timer_cap_nf = 8'h01;
  reg  [7:0] fast_current_setting = 8'h40;
  reg  [7:0] low_current_setting = 8'h10;
  reg  [7:0] r;
  integer    failures, compares, k, n;
  wire [7:0] current_ref;
  wire       charging, precharging, charge_done, fault, sleep_mode;
  wire       adapter_gate_drive, battery_gate_drive, adapter_present;
  wire       input_overvoltage = bad[0];
  wire       die_overheat_shutdown = bad[1];
  wire       thermistor_fault = bad[2];
  wire       regulator_overload = bad[3];
  wire       regulators_good = ~bad[4];
  wire       supply_low_state = bad[5];
  wire       charge_enable = ~bad[6];
  wire       undervoltage_lockout = bad[7];
  wire       supply_above_node = ~bad[8];
  wire [7:0] obs = {adapter_present, battery_gate_drive, adapter_gate_drive, sleep_mode,
                    fault, charge_done, precharging, charging};
  ccps_sequencer #(.TICK_CYC(TK), .PRE_TICKS(PT), .PWRUP_TICKS(PW), .DEAD_CYC(DC),
    .STEP_TICKS(ST), .TTC_TICKS_NF(TN), .IREF_W(8)) dut_u (
    .mclk                  (mclk),
    .arst_n                (arst_n),
    .charge_enable         (charge_enable),
    .battery_low           (battery_low),
    .below_recharge        (below_recharge),
    .current_below_term    (current_below_term),
    .voltage_reg_phase     (voltage_reg_phase),
    .supply_above_node     (supply_above_node),
    .supply_near_node      (supply_near_node),
    .undervoltage_lockout  (undervoltage_lockout),
    .supply_low_state      (supply_low_state),
    .input_overvoltage     (input_overvoltage),
    .die_overheat_shutdown (die_overheat_shutdown),
    .thermistor_fault      (thermistor_fault),
    .regulators_good       (regulators_good),
    .regulator_overload    (regulator_overload),
    .timer_capacitor_pin   (timer_capacitor_pin),
    .timer_cap_nf          (timer_cap_nf),
    .fast_current_setting  (fast_current_setting),
    .low_current_setting   (low_current_setting),
    .current_ref           (current_ref),
    .charging              (charging),
    .precharging           (precharging),
    .charge_done           (charge_done),
    .fault                 (fault),
    .sleep_mode            (sleep_mode),
    .adapter_gate_drive    (adapter_gate_drive),
    .battery_gate_drive    (battery_gate_drive),
    .adapter_present       (adapter_present)
  );
  always #4 mclk = ~mclk;
  ////////////////////////////////////////
  function [7:0] ramp(input [7:0] f, input [3:0] s);
    reg [11:0] p;
    begin
      p = f * s;
      ramp = p[10:3];
    end
  endfunction
  task cyc(input integer c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task till(input [2:0] b, input v);
    integer c;
    c = 0;
    while (obs[b] !== v && c < 600) begin
      cyc(1);
      c = c + 1;
    end
    chk(obs[b], v);
  endtask
  task retog;
    bad[6] = 1'b1;
    cyc(3 * TK);
    bad[6] = 1'b0;
    cyc(1);
  endtask
  task conclude;
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    conclude;
  end
  ////////////////////////////////////////
  initial begin
    failures = 0;
    compares = 0;
    r = $urandom(16420);
    fast_current_setting = 8'h40 | 8'($urandom);
    low_current_setting = 8'($urandom);
    timer_cap_nf = 8'h01 + 8'($urandom % 4);
    cyc(16);
    chk(obs[6:4], 3'b101);
    arst_n = 1'b1;
    cyc(2 * TK);
    chk(charging, 0);
    till(0, 1);
    chk(current_ref, ramp(fast_current_setting, 1));
    for (k = 2; k < 9; k = k + 1) begin
      r = current_ref;
      n = 0;
      while (current_ref === r && n < 40) begin
        cyc(1);
        n = n + 1;
      end
      chk(current_ref, ramp(fast_current_setting, k));
      chk(n <= ST * TK + 1 && (k == 2 || n >= ST * TK - 1), 1);
    end
    chk(obs[7:5], 3'b101);
    voltage_reg_phase = 1'b1;
    current_below_term = 1'b1;
    timer_capacitor_pin = 2'b00;
    cyc(40);
    chk(charge_done, 0);
    timer_capacitor_pin = 2'b10;
    till(2, 1);
    voltage_reg_phase = 1'b0;
    current_below_term = 1'b0;
    below_recharge = 1'b1;
    till(2, 0);
    till(0, 1);
    below_recharge = 1'b0;
    timer_capacitor_pin = 2'b01;
    cyc(timer_cap_nf * TN * TK - TK - 2);
    chk(charging, 1);
    cyc(2 * TK + 6);
    chk(charging, 0);
    timer_capacitor_pin = 2'b10;
    retog;
    till(0, 1);
    for (k = 0; k < 9; k = k + 1) begin
      bad = 9'h001 << k;
      cyc(DC + 4);
      chk(charging, 0);
      if (k > 6) chk(obs[6:5], 2'b10);
      if (k == 8) chk(sleep_mode, 1);
      bad = 9'h000;
      cyc(1);
      if (k > 6) chk(adapter_gate_drive, 0);
      till(5, 1);
      till(0, 1);
    end
    battery_low = 1'b1;
    retog;
    till(1, 1);
    chk(current_ref, low_current_setting);
    cyc(PT * TK - 2 * TK);
    chk(fault, 0);
    till(3, 1);
    chk(charging, 0);
    battery_low = 1'b0;
    retog;
    till(0, 1);
    chk(fault, 0);
    cyc(timer_cap_nf * TN * TK + 2 * TK + 6);
    chk(charging, 1);
    supply_near_node = 1'b1;
    till(6, 1);
    chk(adapter_gate_drive, 0);
    cyc(DC + 2);
    chk(obs[6:5], 2'b10);
    conclude;
  end
endmodule

// file: src/ccps_defines.vh
// Purpose: constants for the charge cycle and power path sequencer
// Assumes: 125 MHz mclk
// Notes:   times kept in their own unit, cycle counts derived from them
`ifndef CCPS_DEFINES_VH
`define CCPS_DEFINES_VH
`define CCPS_CLK_MHZ        125
`define CCPS_TICK_US        100
`define CCPS_TICK_CYC       (`CCPS_TICK_US * `CCPS_CLK_MHZ)
`define CCPS_PRE_MIN        30
`define CCPS_PRE_TICKS      (`CCPS_PRE_MIN * 60 * 10000)
`define CCPS_PWRUP_MS       30
`define CCPS_PWRUP_TICKS    (`CCPS_PWRUP_MS * 10)
`define CCPS_DEAD_US        10
`define CCPS_DEAD_CYC       (`CCPS_DEAD_US * `CCPS_CLK_MHZ)
`define CCPS_STEP_US        1600
`define CCPS_STEP_TICKS     (`CCPS_STEP_US / `CCPS_TICK_US)
`define CCPS_STEPS          8
`define CCPS_KTTC_DMIN_NF   56
`define CCPS_TTC_TICKS_NF   (`CCPS_KTTC_DMIN_NF * 6 * 10000)
`define CCPS_TTC_LOW        2'b00
`define CCPS_TTC_CAP        2'b01
`define CCPS_TTC_REF        2'b10
`define CCPS_ST_IDLE        3'd0
`define CCPS_ST_PRE         3'd1
`define CCPS_ST_FAST        3'd2
`define CCPS_ST_DONE        3'd3
`define CCPS_ST_FAULT       3'd4
`define CCPS_PP_BAT         2'd0
`define CCPS_PP_DEAD_AC     2'd1
`define CCPS_PP_AC          2'd2
`define CCPS_PP_DEAD_BAT    2'd3
`endif

// file: src/ccps_power_path.v
// Purpose: adapter / battery switch selector with break-before-make
// Assumes: comparator inputs synchronous to mclk
// Notes:   battery feeds system by default
`timescale 1ns/1ns
`include "ccps_defines.vh"
module ccps_power_path #(
  parameter DEAD_CYC = `CCPS_DEAD_CYC
) (
  input  wire mclk,
  input  wire arst_n,
  input  wire want_ac,
  input  wire ac_low_margin,
  input  wire force_bat,
  output reg  adapter_gate_drive,
  output reg  battery_gate_drive,
  output wire on_adapter
);
  reg [1:0]  st_r;
  reg [15:0] dead_r;
  assign on_adapter = (st_r == `CCPS_PP_AC);
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r               <= `CCPS_PP_BAT;
      dead_r             <= 16'h0;
      adapter_gate_drive <= 1'b0;
      battery_gate_drive <= 1'b1;
    end else begin
      case (st_r)
        `CCPS_PP_BAT: begin
          adapter_gate_drive <= 1'b0;
          battery_gate_drive <= 1'b1;
          if (want_ac && !force_bat && !ac_low_margin) begin
            st_r               <= `CCPS_PP_DEAD_AC;
            dead_r             <= 16'h0;
            battery_gate_drive <= 1'b0;
          end
        end
        `CCPS_PP_DEAD_AC: begin
          dead_r <= dead_r + 16'h1;
          if (force_bat || !want_ac) begin
            st_r <= `CCPS_PP_DEAD_BAT;
            dead_r <= 16'h0;
          end else if (dead_r == DEAD_CYC - 1) begin
            st_r               <= `CCPS_PP_AC;
            adapter_gate_drive <= 1'b1;
          end
        end
        `CCPS_PP_AC: begin
          if (force_bat || ac_low_margin || !want_ac) begin
            st_r               <= `CCPS_PP_DEAD_BAT;
            dead_r             <= 16'h0;
            adapter_gate_drive <= 1'b0;
          end
        end
        `CCPS_PP_DEAD_BAT: begin
          dead_r <= dead_r + 16'h1;
          if (dead_r == DEAD_CYC - 1) begin
            st_r               <= `CCPS_PP_BAT;
            battery_gate_drive <= 1'b1;
          end
        end
        default: begin
          st_r <= `CCPS_PP_BAT;
        end
      endcase
      if (force_bat && st_r != `CCPS_PP_DEAD_BAT) begin
        adapter_gate_drive <= 1'b0;
      end
    end
  end
endmodule

// file: src/ccps_sequencer.v
// Purpose: charge cycle and power path sequencer top
// Assumes: all inputs synchronous to mclk; 125 MHz
// Notes:   analog loops live outside; this block steers them
// Notes on behaviour
// - low battery at start selects precharge reference
// - precharge over 30 minutes: stop, flag fault
// - terminate when above recharge and current low
// - safety timer 5.6 minutes per nanofarad
// - recharge, reset, enable toggle restart cycle
// - timer pin low: no termination, timer cleared
// - timer pin at reference: termination, no timer
// - timer cleared leaving overvoltage, supply-low, sleep
// - supply above battery node: adapter on, charge
// - battery node above supply: battery on, sleep
// - undervoltage: disabled, adapter off, battery on
// - charge only when every enable condition holds
// - any stop condition ends active charging
// - battery default; adapter 30ms after sleep exit
// - 10us both off before adapter on
// - back to battery within 200mV, same dead time
// - no adapter: adapter off, battery on
// - fast charge ramps in eight 1.6ms steps
`timescale 1ns/1ns
`include "ccps_defines.vh"
module ccps_sequencer #(
  parameter TICK_CYC     = `CCPS_TICK_CYC,
  parameter PRE_TICKS    = `CCPS_PRE_TICKS,
  parameter PWRUP_TICKS  = `CCPS_PWRUP_TICKS,
  parameter DEAD_CYC     = `CCPS_DEAD_CYC,
  parameter STEP_TICKS   = `CCPS_STEP_TICKS,
  parameter TTC_TICKS_NF = `CCPS_TTC_TICKS_NF,
  parameter IREF_W       = 8
) (
  input  wire              mclk,
  input  wire              arst_n,
  input  wire              charge_enable,
  input  wire              battery_low,
  input  wire              below_recharge,
  input  wire              current_below_term,
  input  wire              voltage_reg_phase,
  input  wire              supply_above_node,
  input  wire              supply_near_node,
  input  wire              undervoltage_lockout,
  input  wire              supply_low_state,
  input  wire              input_overvoltage,
  input  wire              die_overheat_shutdown,
  input  wire              thermistor_fault,
  input  wire              regulators_good,
  input  wire              regulator_overload,
  input  wire [1:0]        timer_capacitor_pin,
  input  wire [7:0]        timer_cap_nf,
  input  wire [IREF_W-1:0] fast_current_setting,
  input  wire [IREF_W-1:0] low_current_setting,
  output reg  [IREF_W-1:0] current_ref,
  output reg               charging,
  output reg               precharging,
  output reg               charge_done,
  output reg               fault,
  output reg               sleep_mode,
  output wire              adapter_gate_drive,
  output wire              battery_gate_drive,
  output wire              adapter_present
);
  ////////////////////////////////////////////////////////////////////////////
  // timebase
  wire tick;
  ccps_tick_gen #(.DIV(TICK_CYC)) u_tick (
    .mclk   (mclk),
    .arst_n (arst_n),
    .tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power-up delay, sleep and mode tracking
  reg [15:0] pwrup_r;
  reg [15:0] awake_r;
  reg        ce_tick_r;
  reg        ovp_r;
  reg        low_r;
  reg        slp_r;
  wire       sleep_now = !supply_above_node;
  wire       pwrup_done = (pwrup_r == PWRUP_TICKS);
  wire       ac_ready = (awake_r == PWRUP_TICKS);
  wire       ce_toggle = tick && charge_enable && !ce_tick_r;
  wire       resume = (ovp_r && !input_overvoltage) || (low_r && !supply_low_state)
                      || (slp_r && !sleep_now);
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwrup_r    <= 16'h0;
      awake_r    <= 16'h0;
      ce_tick_r  <= 1'b1;
      ovp_r      <= 1'b0;
      low_r      <= 1'b0;
      slp_r      <= 1'b1;
      sleep_mode <= 1'b1;
    end else begin
      if (tick && !pwrup_done) begin
        pwrup_r <= pwrup_r + 16'h1;
      end
      if (sleep_now || undervoltage_lockout) begin
        awake_r <= 16'h0;
      end else if (tick && !ac_ready) begin
        awake_r <= awake_r + 16'h1;
      end
      if (tick) begin
        ce_tick_r <= charge_enable;
      end
      ovp_r      <= input_overvoltage;
      low_r      <= supply_low_state;
      slp_r      <= sleep_now;
      sleep_mode <= sleep_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power path
  wire on_adapter;
  ccps_power_path #(.DEAD_CYC(DEAD_CYC)) u_path (
    .mclk               (mclk),
    .arst_n             (arst_n),
    .want_ac            (ac_ready && !input_overvoltage),
    .ac_low_margin      (supply_near_node),
    .force_bat          (undervoltage_lockout),
    .adapter_gate_drive (adapter_gate_drive),
    .battery_gate_drive (battery_gate_drive),
    .on_adapter         (on_adapter)
  );
  assign adapter_present = on_adapter;

  ////////////////////////////////////////////////////////////////////////////
  // enable and timer qualification
  wire en_ok = charge_enable && !supply_low_state && !sleep_now && !input_overvoltage
               && pwrup_done && regulators_good && !regulator_overload
               && !die_overheat_shutdown && !thermistor_fault
               && !undervoltage_lockout;
  wire tmr_on = (timer_capacitor_pin == `CCPS_TTC_CAP);
  wire term_on = (timer_capacitor_pin != `CCPS_TTC_LOW);
  wire restart = below_recharge || ce_toggle;

  ////////////////////////////////////////////////////////////////////////////
  // safety timer and precharge timer
  reg  [31:0] sft_r;
  reg  [31:0] pre_r;
  wire [31:0] sft_lim = timer_cap_nf * TTC_TICKS_NF;
  wire        sft_exp = tmr_on && (sft_r >= sft_lim);
  reg  [2:0]  st_r;
  reg  [2:0]  st_nxt;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sft_r <= 32'h0;
      pre_r <= 32'h0;
    end else begin
      if (restart || resume || !tmr_on) begin
        sft_r <= 32'h0;
      end else if (tick && st_r == `CCPS_ST_FAST && !sft_exp) begin
        sft_r <= sft_r + 32'h1;
      end
      if (st_r != `CCPS_ST_PRE) begin
        pre_r <= 32'h0;
      end else if (tick) begin
        pre_r <= pre_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge state machine
  always @* begin
    st_nxt = st_r;
    case (st_r)
      `CCPS_ST_IDLE: begin
        if (en_ok) begin
          st_nxt = battery_low ? `CCPS_ST_PRE : `CCPS_ST_FAST;
        end
      end
      `CCPS_ST_PRE: begin
        if (!en_ok) begin
          st_nxt = `CCPS_ST_IDLE;
        end else if (pre_r >= PRE_TICKS) begin
          st_nxt = `CCPS_ST_FAULT;
        end else if (!battery_low) begin
          st_nxt = `CCPS_ST_FAST;
        end
      end
      `CCPS_ST_FAST: begin
        if (!en_ok) begin
          st_nxt = `CCPS_ST_IDLE;
        end else if (sft_exp) begin
          st_nxt = `CCPS_ST_FAULT;
        end else if (term_on && voltage_reg_phase && !below_recharge && current_below_term) begin
          st_nxt = `CCPS_ST_DONE;
        end
      end
      `CCPS_ST_DONE: begin
        if (restart) begin
          st_nxt = `CCPS_ST_IDLE;
        end
      end
      `CCPS_ST_FAULT: begin
        if (ce_toggle) begin
          st_nxt = `CCPS_ST_IDLE;
        end
      end
      default: begin
        st_nxt = `CCPS_ST_IDLE;
      end
    endcase
    if (ce_toggle && st_r != `CCPS_ST_IDLE) begin
      st_nxt = `CCPS_ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft-start ramp and outputs
  reg [3:0]  step_r;
  reg [15:0] stp_cnt_r;
  function [IREF_W-1:0] ramp_level;
    input [IREF_W-1:0] full;
    input [3:0]        step;
    reg   [IREF_W+3:0] prod;
    begin
      prod       = full * step;
      ramp_level = prod[IREF_W+2:3];
    end
  endfunction
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r        <= `CCPS_ST_IDLE;
      step_r      <= 4'h0;
      stp_cnt_r   <= 16'h0;
      current_ref <= {IREF_W{1'b0}};
      charging    <= 1'b0;
      precharging <= 1'b0;
      charge_done <= 1'b0;
      fault       <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt == `CCPS_ST_FAST && st_r != `CCPS_ST_FAST) begin
        step_r    <= 4'h1;
        stp_cnt_r <= 16'h0;
      end else if (tick && step_r < `CCPS_STEPS) begin
        if (stp_cnt_r == STEP_TICKS - 1) begin
          stp_cnt_r <= 16'h0;
          step_r    <= step_r + 4'h1;
        end else begin
          stp_cnt_r <= stp_cnt_r + 16'h1;
        end
      end
      case (st_nxt)
        `CCPS_ST_PRE:  current_ref <= low_current_setting;
        `CCPS_ST_FAST: current_ref <= ramp_level(fast_current_setting,
                                                 (st_r == `CCPS_ST_FAST) ? step_r : 4'h1);
        default:       current_ref <= {IREF_W{1'b0}};
      endcase
      charging    <= (st_nxt == `CCPS_ST_PRE) || (st_nxt == `CCPS_ST_FAST);
      precharging <= (st_nxt == `CCPS_ST_PRE);
      charge_done <= (st_nxt == `CCPS_ST_DONE);
      fault       <= (st_nxt == `CCPS_ST_FAULT);
    end
  end
endmodule

// file: src/ccps_tick_gen.v
// Purpose: slow internal timebase tick
// Assumes: one clock domain
// Notes:   one-cycle pulse every div cycles
`timescale 1ns/1ns
module ccps_tick_gen #(
  parameter DIV = 12500
) (
  input  wire mclk,
  input  wire arst_n,
  output reg  tick
);
  reg [31:0] cnt_r;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
